// ===== hdl/asc_pkg.sv
package asc_pkg;

	////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] CSR_ADDR = 8'h34;
	localparam logic [7:0] HIGH_ADDR = 8'h35;
	localparam logic [7:0] LOW_ADDR = 8'h36;
	localparam logic [7:0] EVT_STAT_ADDR = 8'h37;
	localparam logic [7:0] EVT_EN_ADDR = 8'h38;
	localparam logic [7:0] EVT_CLR_ADDR = 8'h39;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int CSR_DONE_BIT = 7;
	localparam int CSR_SPEED_BIT = 6;
	localparam int CSR_ON_BIT = 5;
	localparam int CSR_SEL_LSB = 0;
	localparam int CH_BITS = 3;
	localparam int LOW_SLOW_BIT = 3;
	localparam int RESULT_BITS = 10;
	localparam int EVT_BITS = 2;
	localparam int EVT_DONE = 0;
	localparam int EVT_ABORT = 1;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] CSR_RESET = 8'h00;
	localparam logic [7:0] HIGH_RESET = 8'h00;
	localparam logic [7:0] LOW_RESET = 8'h00;
	localparam logic [EVT_BITS-1:0] EVT_EN_RESET = 2'h0;

	////////////////////////////////////////////////////////////////////////
	// conversion clock divider terminal counts
	localparam logic [1:0] DIV1_LAST = 2'h0;
	localparam logic [1:0] DIV2_LAST = 2'h1;
	localparam logic [1:0] DIV4_LAST = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_FREQ_HZ = 40_000_000;
	localparam int SAMPLE_TICKS = 4;
	localparam int BIT_TICKS = 4;
	localparam int TICK_CNT_BITS = 4;
	localparam int STAB_TIME_NS = 1000;
	localparam int STAB_CYCLES =
		(STAB_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
	localparam int STAB_CNT_BITS = 16;

	typedef enum logic [1:0] {
		ASC_IDLE = 2'b00,
		ASC_SAMPLE = 2'b01,
		ASC_CONVERT = 2'b10
	} asc_sar_state_t;

endpackage

// ===== hdl/asc_conv_if.sv
`timescale 1ns/100ps
interface asc_conv_if import asc_pkg::*; ();
	logic tick;
	logic run;
	logic restart;
	logic cmpIn;
	logic done;
	logic busy;
	logic sample;
	logic [RESULT_BITS-1:0] result;
	logic [RESULT_BITS-1:0] trialCode;

	modport engine(input tick, input run, input restart, input cmpIn,
		output done, output busy, output sample, output result,
		output trialCode);
	modport ctrl(output tick, output run, output restart, output cmpIn,
		input done, input busy, input sample, input result,
		input trialCode);
endinterface

// ===== hdl/asc_clk_div.sv
`timescale 1ns/100ps
module asc_clk_div import asc_pkg::*; (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic enable,
	input wire logic slowSel,
	input wire logic speedSel,
	output logic tick
);

	typedef struct packed {
		logic [1:0] cnt;
		logic tick;
	} asc_div_state_t;

	asc_div_state_t div_r;
	asc_div_state_t div_nxt;
	logic [1:0] lastCnt;

	always_comb begin
		lastCnt = slowSel ? DIV4_LAST : (speedSel ? DIV1_LAST : DIV2_LAST);
		div_nxt = div_r;
		if (!enable) begin
			div_nxt.cnt = 2'h0;
			div_nxt.tick = 1'b0;
		end else if (div_r.cnt >= lastCnt) begin
			div_nxt.cnt = 2'h0;
			div_nxt.tick = 1'b1;
		end else begin
			div_nxt.cnt = div_r.cnt + 2'h1;
			div_nxt.tick = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_r <= '0;
		end else begin
			div_r <= div_nxt;
		end
	end

	assign tick = div_r.tick;

endmodule

// ===== hdl/asc_sar_engine.sv
`timescale 1ns/100ps
module asc_sar_engine import asc_pkg::*; #(
	parameter int SAMPLE_LEN = SAMPLE_TICKS,
	parameter int BIT_LEN = BIT_TICKS
) (
	input wire logic core_clk,
	input wire logic rst_b,
	asc_conv_if.engine conv
);

	typedef struct packed {
		asc_sar_state_t state;
		logic [TICK_CNT_BITS-1:0] cnt;
		logic [3:0] bitIdx;
		logic [RESULT_BITS-1:0] code;
		logic [RESULT_BITS-1:0] result;
		logic done;
		logic sample;
	} asc_sar_regs_t;

	asc_sar_regs_t sar_r;
	asc_sar_regs_t sar_nxt;

	always_comb begin
		sar_nxt = sar_r;
		sar_nxt.done = 1'b0;
		if (!conv.run) begin
			sar_nxt.state = ASC_IDLE;
			sar_nxt.cnt = '0;
			sar_nxt.code = '0;
			sar_nxt.sample = 1'b0;
		end else if (conv.restart || sar_r.state == ASC_IDLE) begin
			sar_nxt.state = ASC_SAMPLE;
			sar_nxt.cnt = '0;
			sar_nxt.code = '0;
			sar_nxt.sample = 1'b1;
		end else if (conv.tick) begin
			case (sar_r.state)
				ASC_SAMPLE: begin
					if (sar_r.cnt == TICK_CNT_BITS'(SAMPLE_LEN - 1)) begin
						sar_nxt.state = ASC_CONVERT;
						sar_nxt.cnt = '0;
						sar_nxt.sample = 1'b0;
						sar_nxt.bitIdx = 4'(RESULT_BITS - 1);
						sar_nxt.code = 10'h200;
					end else begin
						sar_nxt.cnt = sar_r.cnt + 4'h1;
					end
				end
				ASC_CONVERT: begin
					if (sar_r.cnt == TICK_CNT_BITS'(BIT_LEN - 1)) begin
						sar_nxt.cnt = '0;
						// trial kept while input is at or above it; saturates
						if (!conv.cmpIn) begin
							sar_nxt.code[sar_r.bitIdx] = 1'b0;
						end
						if (sar_r.bitIdx == 4'h0) begin
							sar_nxt.result = sar_nxt.code;
							sar_nxt.done = 1'b1;
							sar_nxt.state = ASC_SAMPLE;
							sar_nxt.sample = 1'b1;
							sar_nxt.code = '0;
						end else begin
							sar_nxt.bitIdx = sar_r.bitIdx - 4'h1;
							sar_nxt.code[sar_r.bitIdx - 4'h1] = 1'b1;
						end
					end else begin
						sar_nxt.cnt = sar_r.cnt + 4'h1;
					end
				end
				default: begin
					sar_nxt.state = ASC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sar_r <= '0;
		end else begin
			sar_r <= sar_nxt;
		end
	end

	assign conv.done = sar_r.done;
	assign conv.busy = (sar_r.state != ASC_IDLE);
	assign conv.sample = sar_r.sample;
	assign conv.result = sar_r.result;
	assign conv.trialCode = sar_r.code;

endmodule

// ===== hdl/asc_adc_sar_control.sv
`timescale 1ns/100ps
// What this block does
// - converter on powers converter and converts selected input continuously
// - converter on cleared switches converter off and stops converting
// - each finished conversion sets done flag bit 7 and stores result
// - high byte read or any status write clears done flag
// - new input select during conversion aborts, clears flag, restarts
// - input select bits 2:0 pick analog input zero to six
// - conversion clock: cpu/2, cpu, or cpu/4 from slow and speed
// - result 9:2 in high byte, 1:0 in low byte bits 1:0
// - low register bits 7:4 and 2 always read zero
// - input out of range saturates to all ones or all zeros
// - status register bits 6:5 and 2:0 read/write; done flag read only; bits 4:3 always read zero
// - wait mode no effect; halt disables, then stabilisation before use
module asc_adc_sar_control import asc_pkg::*; #(
	parameter int STAB_LEN = STAB_CYCLES,
	parameter int SAMPLE_LEN = SAMPLE_TICKS,
	parameter int BIT_LEN = BIT_TICKS
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [7:0] regRdData,
	input wire logic haltMode,
	input wire logic anaCompare,
	output logic anaPowerOn,
	output logic [CH_BITS-1:0] anaChannel,
	output logic anaSample,
	output logic [RESULT_BITS-1:0] anaTrialCode,
	output logic irqOut
);

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [CH_BITS-1:0] chSel;
		logic speed;
		logic convOn;
		logic slow;
		logic doneFlag;
		logic [RESULT_BITS-1:0] data;
		logic [EVT_BITS-1:0] evtStat;
		logic [EVT_BITS-1:0] evtEn;
		logic irq;
		logic [7:0] rdData;
		logic cmpMeta;
		logic cmpSync;
		logic [STAB_CNT_BITS-1:0] stabCnt;
		logic stabOk;
		logic powerOn;
	} asc_ctrl_regs_t;

	localparam asc_ctrl_regs_t CTRL_RESET = '{
		chSel: CSR_RESET[CSR_SEL_LSB +: CH_BITS],
		speed: CSR_RESET[CSR_SPEED_BIT],
		convOn: CSR_RESET[CSR_ON_BIT],
		slow: LOW_RESET[LOW_SLOW_BIT],
		doneFlag: CSR_RESET[CSR_DONE_BIT],
		data: {HIGH_RESET, LOW_RESET[1:0]},
		evtStat: '0,
		evtEn: EVT_EN_RESET,
		irq: 1'b0,
		rdData: 8'h00,
		cmpMeta: 1'b0,
		cmpSync: 1'b0,
		stabCnt: '0,
		stabOk: 1'b1,
		powerOn: 1'b0
	};

	asc_ctrl_regs_t ctrl_r;
	asc_ctrl_regs_t ctrl_nxt;

	asc_conv_if conv();

	logic divTick;
	logic csrWr;
	logic lowWr;
	logic enWr;
	logic clrWr;
	logic highRd;
	logic selChange;
	logic [EVT_BITS-1:0] evtSet;

	////////////////////////////////////////////////////////////////////////
	// conversion clock and sequencer

	asc_clk_div u_div (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.enable(conv.run),
		.slowSel(ctrl_r.slow),
		.speedSel(ctrl_r.speed),
		.tick(divTick)
	);

	asc_sar_engine #(
		.SAMPLE_LEN(SAMPLE_LEN),
		.BIT_LEN(BIT_LEN)
	) u_sar (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.conv(conv)
	);

	// halt stops conversion; wait mode needs nothing here
	assign conv.run = ctrl_r.convOn && !haltMode && ctrl_r.stabOk;
	assign conv.tick = divTick;
	assign conv.cmpIn = ctrl_r.cmpSync;
	assign conv.restart = selChange;

	////////////////////////////////////////////////////////////////////////
	// address decode

	always_comb begin
		csrWr = 1'b0;
		lowWr = 1'b0;
		enWr = 1'b0;
		clrWr = 1'b0;
		if (!regWrStb) begin
			csrWr = 1'b0;
		end else if (regAddr == CSR_ADDR) begin
			csrWr = 1'b1;
		end else if (regAddr == LOW_ADDR) begin
			lowWr = 1'b1;
		end else if (regAddr == EVT_EN_ADDR) begin
			enWr = 1'b1;
		end else if (regAddr == EVT_CLR_ADDR) begin
			clrWr = 1'b1;
		end
	end

	assign highRd = regRdStb && (regAddr == HIGH_ADDR);

	// new input select while converting: abort and restart
	assign selChange = csrWr && conv.busy && conv.run &&
		(regWrData[CSR_SEL_LSB +: CH_BITS] != ctrl_r.chSel);

	assign evtSet[EVT_DONE] = conv.done;
	assign evtSet[EVT_ABORT] = selChange;

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		ctrl_nxt = ctrl_r;

		ctrl_nxt.cmpMeta = anaCompare;
		ctrl_nxt.cmpSync = ctrl_r.cmpMeta;

		if (csrWr) begin
			// done flag position is ignored on write
			ctrl_nxt.chSel = regWrData[CSR_SEL_LSB +: CH_BITS];
			ctrl_nxt.speed = regWrData[CSR_SPEED_BIT];
			ctrl_nxt.convOn = regWrData[CSR_ON_BIT];
		end
		if (lowWr) begin
			ctrl_nxt.slow = regWrData[LOW_SLOW_BIT];
		end

		// set wins over clear
		if (conv.done) begin
			ctrl_nxt.doneFlag = 1'b1;
			ctrl_nxt.data = conv.result;
		end else if (csrWr || highRd) begin
			ctrl_nxt.doneFlag = 1'b0;
		end

		if (haltMode) begin
			ctrl_nxt.stabCnt = '0;
			ctrl_nxt.stabOk = 1'b0;
		end else if (!ctrl_r.stabOk) begin
			if (ctrl_r.stabCnt == STAB_CNT_BITS'(STAB_LEN - 1)) begin
				ctrl_nxt.stabOk = 1'b1;
			end else begin
				ctrl_nxt.stabCnt = ctrl_r.stabCnt + 16'h0001;
			end
		end
		ctrl_nxt.powerOn = ctrl_nxt.convOn && !haltMode;

		if (clrWr) begin
			ctrl_nxt.evtStat = ctrl_r.evtStat & ~regWrData[EVT_BITS-1:0];
		end
		ctrl_nxt.evtStat = ctrl_nxt.evtStat | evtSet;
		if (enWr) begin
			ctrl_nxt.evtEn = regWrData[EVT_BITS-1:0];
		end
		ctrl_nxt.irq = |(ctrl_nxt.evtStat & ctrl_nxt.evtEn);

		// read data stands only in the cycle after the strobe
		ctrl_nxt.rdData = 8'h00;
		if (!regRdStb) begin
			ctrl_nxt.rdData = 8'h00;
		end else if (regAddr == CSR_ADDR) begin
			ctrl_nxt.rdData[CSR_DONE_BIT] = ctrl_r.doneFlag;
			ctrl_nxt.rdData[CSR_SPEED_BIT] = ctrl_r.speed;
			ctrl_nxt.rdData[CSR_ON_BIT] = ctrl_r.convOn;
			ctrl_nxt.rdData[CSR_SEL_LSB +: CH_BITS] = ctrl_r.chSel;
		end else if (regAddr == HIGH_ADDR) begin
			ctrl_nxt.rdData = ctrl_r.data[RESULT_BITS-1:2];
		end else if (regAddr == LOW_ADDR) begin
			ctrl_nxt.rdData[1:0] = ctrl_r.data[1:0];
			ctrl_nxt.rdData[LOW_SLOW_BIT] = ctrl_r.slow;
		end else if (regAddr == EVT_STAT_ADDR) begin
			ctrl_nxt.rdData[EVT_BITS-1:0] = ctrl_r.evtStat;
		end else if (regAddr == EVT_EN_ADDR) begin
			ctrl_nxt.rdData[EVT_BITS-1:0] = ctrl_r.evtEn;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r <= CTRL_RESET;
		end else begin
			ctrl_r <= ctrl_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign regRdData = ctrl_r.rdData;
	assign anaPowerOn = ctrl_r.powerOn;
	assign anaChannel = ctrl_r.chSel;
	assign anaSample = conv.sample;
	assign anaTrialCode = conv.trialCode;
	assign irqOut = ctrl_r.irq;

endmodule

// ===== tb/asc_adc_sar_control_properties.sv
`timescale 1ns/100ps
module asc_adc_sar_control_properties import asc_pkg::*; #(
	parameter int STAB_LEN = 4,
	parameter int SAMPLE_LEN = 4,
	parameter int BIT_LEN = 4
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	input wire logic [7:0] regRdData,
	input wire logic haltMode,
	input wire logic anaCompare,
	input wire logic anaPowerOn,
	input wire logic [CH_BITS-1:0] anaChannel,
	input wire logic anaSample,
	input wire logic [RESULT_BITS-1:0] anaTrialCode,
	input wire logic irqOut
);
	localparam int MIN_SPAN = 10 * BIT_LEN - 1;
	logic csrWr;
	logic quiet;
	logic enSet_r;
	logic [7:0] span_r;
	assign csrWr = regWrStb && regAddr == CSR_ADDR;
	assign quiet = !csrWr && !haltMode;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////////
	// cycles without sampling since the last sample phase, saturating
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			enSet_r <= 1'b0;
			span_r <= 8'hFF;
		end else begin
			if (regWrStb && regAddr == EVT_EN_ADDR) begin
				enSet_r <= enSet_r || regWrData != 8'h00;
			end
			if (!quiet) begin
				span_r <= 8'hFF;
			end else if (anaSample) begin
				span_r <= 8'h00;
			end else if (span_r != 8'hFF) begin
				span_r <= span_r + 8'h01;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	sequence offWr;
		csrWr && !anaPowerOn;
	endsequence
	sequence csrRd;
		regRdStb && regAddr == CSR_ADDR;
	endsequence
	sequence chanSettled;
		csrWr ##1 !csrWr [*2];
	endsequence
	power_off_a: assert property (csrWr && !regWrData[CSR_ON_BIT]
		|-> ##[1:2] !anaPowerOn) else $error("power stays on");
	halt_off_a: assert property (haltMode [*3]
		|-> !anaPowerOn && !anaSample) else $error("halt ignored");
	chan_follow_a: assert property (chanSettled
		|-> anaChannel == 3'($past(regWrData, 2))) else $error("bad input");
	low_rsvd_a: assert property ($past(regRdStb)
		&& $past(regAddr) == LOW_ADDR |-> regRdData[7:4] == 4'h0
		&& !regRdData[2]) else $error("low reserved set");
	done_clr_a: assert property (offWr ##2 csrRd
		|=> !regRdData[CSR_DONE_BIT] && regRdData[4:3] == 2'b00)
		else $error("status readback");
	sample_len_a: assert property ($rose(anaSample)
		|-> anaSample [*4] or ##[0:3] !quiet) else $error("short sample");
	trial_msb_a: assert property ($fell(anaSample) && anaPowerOn
		&& $past(quiet) |-> ##[0:1] anaTrialCode == 10'h200)
		else $error("first trial");
	conv_span_a: assert property ($rose(anaSample)
		|-> span_r >= 8'(MIN_SPAN)) else $error("short conversion");
	irq_quiet_a: assert property (!enSet_r
		|-> !irqOut) else $error("unrequested interrupt");
endmodule
bind asc_adc_sar_control asc_adc_sar_control_properties #(
	.STAB_LEN(STAB_LEN), .SAMPLE_LEN(SAMPLE_LEN), .BIT_LEN(BIT_LEN)
) props (.core_clk, .rst_b, .regAddr, .regWrData, .regWrStb, .regRdStb,
	.regRdData, .haltMode, .anaCompare, .anaPowerOn, .anaChannel,
	.anaSample, .anaTrialCode, .irqOut);

// ===== tb/asc_analog_model.sv
`timescale 1ns/100ps
module asc_analog_model import asc_pkg::*; (
	input wire logic core_clk,
	input wire logic powerOn,
	input wire logic [CH_BITS-1:0] channel,
	input wire logic [RESULT_BITS-1:0] trialCode,
	input wire logic [6:0][RESULT_BITS-1:0] levels,
	output logic compare
);
	logic toggle = 1'b0;
	always @(posedge core_clk) begin
		toggle <= !toggle;
	end
	// unpowered or absent input gives a moving value
	assign compare = (!powerOn || channel > 3'h6) ? toggle :
		levels[channel] >= trialCode;
endmodule

// ===== tb/asc_adc_sar_control_bench.sv
`timescale 1ns/100ps
module asc_adc_sar_control_bench import asc_pkg::*;;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWrStb = 1'b0;
	logic regRdStb = 1'b0;
	logic haltMode = 1'b0;
	logic [7:0] regRdData;
	logic anaCompare, anaPowerOn, anaSample, irqOut;
	logic [CH_BITS-1:0] anaChannel;
	logic [RESULT_BITS-1:0] anaTrialCode;
	logic [6:0][RESULT_BITS-1:0] levels;
	logic [7:0] d;
	logic [2:0] ch;
	logic slow, spd;
	logic [7:0] regList [4] = '{CSR_ADDR, HIGH_ADDR, LOW_ADDR, 8'h50};
	int error_cnt = 0;
	int compares = 0;
	asc_adc_sar_control #(.STAB_LEN(4)) dut (.core_clk, .rst_b, .regAddr,
		.regWrData, .regWrStb, .regRdStb, .regRdData, .haltMode,
		.anaCompare, .anaPowerOn, .anaChannel, .anaSample, .anaTrialCode,
		.irqOut);
	asc_analog_model model (.core_clk, .powerOn(anaPowerOn),
		.channel(anaChannel), .trialCode(anaTrialCode), .levels,
		.compare(anaCompare));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lowExp(logic s, logic [9:0] v);
		return {4'h0, s, 1'b0, v[1:0]};
	endfunction
	function automatic logic [7:0] csrExp(logic [7:0] v);
		return {1'b0, v[6:5], 2'b00, v[2:0]};
	endfunction
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= v;
		regWrStb <= 1'b1;
		@(posedge core_clk);
		regWrStb <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge core_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge core_clk);
		regRdStb <= 1'b0;
		#1 v = regRdData;
	endtask
	task automatic waitDone();
		d = 8'h00;
		for (int n = 0; n < 400 && d[7] !== 1'b1; n++) begin
			rd(CSR_ADDR, d);
		end
		chk(10'(d[7]), 10'h001);
	endtask
	task automatic tally_and_finish();
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		#(25 * 40000);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'h9470));
		for (int i = 0; i < 7; i++) begin
			levels[i] = 10'($urandom);
		end
		levels[0] = 10'h3FF;
		levels[1] = 10'h000;
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		foreach (regList[k]) begin
			rd(regList[k], d);
			chk(10'(d), 10'h000);
		end
		wr(CSR_ADDR, 8'hC7);
		rd(CSR_ADDR, d);
		chk(10'(d), 10'(csrExp(8'hC7)));
		wr(LOW_ADDR, 8'hFF);
		rd(LOW_ADDR, d);
		chk(10'(d), 10'(lowExp(1'b1, 10'h000)));
		for (int i = 0; i < 7; i++) begin
			ch = 3'(6 - i);
			{slow, spd} = 2'(i % 3);
			wr(LOW_ADDR, {4'h0, slow, 3'h0});
			wr(CSR_ADDR, {1'b0, spd, 1'b1, 2'b00, ch});
			waitDone();
			rd(LOW_ADDR, d);
			chk(10'(d), 10'(lowExp(slow, levels[ch])));
			rd(CSR_ADDR, d);
			chk(10'(d[7]), 10'h001);
			rd(HIGH_ADDR, d);
			chk(10'(d), 10'(levels[ch][9:2]));
			rd(CSR_ADDR, d);
			chk(10'(d[7]), 10'h000);
		end
		waitDone();
		rd(HIGH_ADDR, d);
		chk(10'(d), 10'(levels[ch][9:2]));
		rd(CSR_ADDR, d);
		chk(10'(d[7]), 10'h000);
		@(posedge core_clk);
		haltMode <= 1'b1;
		repeat (4) @(posedge core_clk);
		#1 chk(10'(anaPowerOn), 10'h000);
		@(posedge core_clk);
		haltMode <= 1'b0;
		wr(EVT_EN_ADDR, 8'h01);
		waitDone();
		repeat (2) @(posedge core_clk);
		#1 chk(10'(irqOut), 10'h001);
		wr(EVT_EN_ADDR, 8'h00);
		repeat (2) @(posedge core_clk);
		#1 chk(10'(irqOut), 10'h000);
		wr(CSR_ADDR, 8'h00);
		repeat (3) @(posedge core_clk);
		#1 chk(10'({anaPowerOn, anaSample}), 10'h000);
		rd(EVT_STAT_ADDR, d);
		chk(10'(d[0]), 10'h001);
		wr(EVT_CLR_ADDR, 8'h03);
		rd(EVT_STAT_ADDR, d);
		chk(10'(d), 10'h000);
		tally_and_finish();
	end
endmodule
